// *** logic/qdc_queue_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "qdc_defs.svh"
module qdc_queue_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [1:0] reg_be,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_ff,
  output logic reg_ack_ff,
  output logic reg_refused_ff,
  // data register access
  input wire logic fifo_req,
  input wire logic fifo_wr,
  input wire qdc_pkg::qdc_size_e fifo_size,
  output logic fifo_grant_ff,
  output logic fifo_refused_ff,
  output logic dma_access_ff,
  // receive queue state and limits
  input wire logic [15:0] rxq_frames,
  input wire logic [15:0] rxq_bytes,
  input wire logic [15:0] frame_limit,
  input wire logic [15:0] byte_limit,
  input wire logic [15:0] duration_limit,
  input wire logic rx_irq_ack,
  input wire logic rx_frame_read_done,
  input wire logic release_done,
  output logic rx_irq_req_ff,
  output logic ip_align_offset_en_ff,
  output logic rxq_dequeue_ff,
  output logic release_req_ff,
  // transmit queue
  input wire logic tx_enqueued,
  input wire logic [10:0] tx_next_free,
  output logic [10:0] tx_pointer_ff
);
  logic dur_en_ff;
  logic byte_en_ff;
  logic frm_en_ff;
  logic adeq_ff;
  logic autoinc_ff;
  logic nxt_ip;
  logic nxt_dur_en;
  logic nxt_byte_en;
  logic nxt_frm_en;
  logic nxt_adeq;
  logic nxt_dma;
  logic nxt_rel;
  logic nxt_autoinc;
  logic [10:0] nxt_ptr;
  logic [15:0] nxt_rdata;
  logic nxt_ack;
  logic nxt_refused;
  logic nxt_grant;
  logic nxt_frefused;
  logic nxt_irq;
  logic nxt_deq;
  logic cmd_hit;
  logic ptr_hit;
  logic wr_cmd;
  logic wr_ptr;
  logic blocked;
  logic fifo_ok;
  logic [10:0] step;
  logic dur_live;
  logic byte_live;
  logic frm_live;
  logic dur_st;
  logic byte_st;
  logic frm_st;

  // ==========================================
  // decode
  always_comb begin
    cmd_hit = (reg_addr[7:1] == `QDC_IDX_CMD);
    ptr_hit = (reg_addr[7:1] == `QDC_IDX_PTR);
    // only the command register stays reachable during fifo access
    blocked = (reg_wr || reg_rd) && dma_access_ff && !cmd_hit;
    wr_cmd = reg_wr && cmd_hit;
    wr_ptr = reg_wr && ptr_hit && !dma_access_ff;
    fifo_ok = fifo_req && dma_access_ff;
    unique case (fifo_size)
      qdc_pkg::QDC_SZ_BYTE: step = `QDC_STEP_B;
      qdc_pkg::QDC_SZ_WORD: step = `QDC_STEP_W;
      qdc_pkg::QDC_SZ_DWORD: step = `QDC_STEP_D;
      default: step = `QDC_STEP_B;
    endcase
    frm_live = rxq_frames > frame_limit;
    byte_live = rxq_bytes > byte_limit;
  end

  // ==========================================
  // threshold causes
  qdc_us_timer u_dur (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(rxq_frames != 16'h0000),
    .limit(duration_limit),
    .over_ff(dur_live)
  );

  qdc_cause_flag u_dur_flag (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .en(dur_en_ff),
    .live(dur_live),
    .ack(rx_irq_ack),
    .flag_ff(dur_st)
  );

  qdc_cause_flag u_byte_flag (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .en(byte_en_ff),
    .live(byte_live),
    .ack(rx_irq_ack),
    .flag_ff(byte_st)
  );

  qdc_cause_flag u_frm_flag (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .en(frm_en_ff),
    .live(frm_live),
    .ack(rx_irq_ack),
    .flag_ff(frm_st)
  );

  // ==========================================
  // command register
  always_comb begin
    nxt_ip = ip_align_offset_en_ff;
    nxt_dur_en = dur_en_ff;
    nxt_byte_en = byte_en_ff;
    nxt_frm_en = frm_en_ff;
    nxt_adeq = adeq_ff;
    nxt_dma = dma_access_ff;
    // release holds until the memory is freed; a new request wins
    nxt_rel = release_req_ff && !release_done;
    if (wr_cmd && reg_be[1]) begin
      nxt_ip = reg_wdata[`QDC_IP_ALIGN];
    end
    if (wr_cmd && reg_be[0]) begin
      nxt_dur_en = reg_wdata[`QDC_DUR_EN];
      nxt_byte_en = reg_wdata[`QDC_BYTE_EN];
      nxt_frm_en = reg_wdata[`QDC_FRM_EN];
      nxt_adeq = reg_wdata[`QDC_ADEQ];
      nxt_dma = reg_wdata[`QDC_DMA];
      if (reg_wdata[`QDC_RELEASE]) begin
        nxt_rel = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ip_align_offset_en_ff <= `QDC_BIT_RST;
      dur_en_ff <= `QDC_BIT_RST;
      byte_en_ff <= `QDC_BIT_RST;
      frm_en_ff <= `QDC_BIT_RST;
      adeq_ff <= `QDC_BIT_RST;
      dma_access_ff <= `QDC_BIT_RST;
      release_req_ff <= `QDC_BIT_RST;
    end else begin
      ip_align_offset_en_ff <= nxt_ip;
      dur_en_ff <= nxt_dur_en;
      byte_en_ff <= nxt_byte_en;
      frm_en_ff <= nxt_frm_en;
      adeq_ff <= nxt_adeq;
      dma_access_ff <= nxt_dma;
      release_req_ff <= nxt_rel;
    end
  end

  // ==========================================
  // transmit pointer
  always_comb begin
    nxt_autoinc = autoinc_ff;
    nxt_ptr = tx_pointer_ff;
    if (wr_ptr && reg_be[1]) begin
      nxt_autoinc = reg_wdata[`QDC_AUTOINC];
    end
    // reload after enqueue beats a same-cycle increment
    if (tx_enqueued) begin
      nxt_ptr = tx_next_free;
    end else if (fifo_ok && fifo_wr && autoinc_ff) begin
      nxt_ptr = 11'(tx_pointer_ff + step);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      autoinc_ff <= `QDC_BIT_RST;
      tx_pointer_ff <= `QDC_PTR_RST;
    end else begin
      autoinc_ff <= nxt_autoinc;
      tx_pointer_ff <= nxt_ptr;
    end
  end

  // ==========================================
  // answers
  always_comb begin
    nxt_ack = reg_wr || reg_rd;
    nxt_refused = blocked;
    nxt_rdata = `QDC_WORD_RST;
    if (reg_rd && cmd_hit) begin
      nxt_rdata[`QDC_DUR_ST] = dur_st;
      nxt_rdata[`QDC_BYTE_ST] = byte_st;
      nxt_rdata[`QDC_FRM_ST] = frm_st;
      nxt_rdata[`QDC_IP_ALIGN] = ip_align_offset_en_ff;
      nxt_rdata[`QDC_DUR_EN] = dur_en_ff;
      nxt_rdata[`QDC_BYTE_EN] = byte_en_ff;
      nxt_rdata[`QDC_FRM_EN] = frm_en_ff;
      nxt_rdata[`QDC_ADEQ] = adeq_ff;
      nxt_rdata[`QDC_RELEASE] = release_req_ff;
    end else if (reg_rd && ptr_hit && !dma_access_ff) begin
      nxt_rdata[`QDC_AUTOINC] = autoinc_ff;
      nxt_rdata[`QDC_PTR_HI:0] = tx_pointer_ff;
    end
    nxt_grant = fifo_ok;
    nxt_frefused = fifo_req && !dma_access_ff;
    nxt_irq = (dur_en_ff && dur_live) || (byte_en_ff && byte_live)
      || (frm_en_ff && frm_live);
    nxt_deq = adeq_ff && rx_frame_read_done;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= `QDC_WORD_RST;
      reg_ack_ff <= `QDC_BIT_RST;
      reg_refused_ff <= `QDC_BIT_RST;
      fifo_grant_ff <= `QDC_BIT_RST;
      fifo_refused_ff <= `QDC_BIT_RST;
      rx_irq_req_ff <= `QDC_BIT_RST;
      rxq_dequeue_ff <= `QDC_BIT_RST;
    end else begin
      reg_rdata_ff <= nxt_rdata;
      reg_ack_ff <= nxt_ack;
      reg_refused_ff <= nxt_refused;
      fifo_grant_ff <= nxt_grant;
      fifo_refused_ff <= nxt_frefused;
      rx_irq_req_ff <= nxt_irq;
      rxq_dequeue_ff <= nxt_deq;
    end
  end

  // ==========================================
  // checks
  AST_BLOCK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && dma_access_ff && !cmd_hit |=> reg_refused_ff && reg_ack_ff
      && reg_rdata_ff == 16'h0000)
    else $error("register reachable during fifo access");
  AST_FIFO_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fifo_req |=> fifo_grant_ff == $past(dma_access_ff) && fifo_refused_ff != fifo_grant_ff)
    else $error("fifo gate wrong");
  AST_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fifo_ok && fifo_wr && autoinc_ff && !tx_enqueued && fifo_size == qdc_pkg::QDC_SZ_DWORD
      |=> tx_pointer_ff == 11'($past(tx_pointer_ff) + 11'h004))
    else $error("pointer did not step by four");
  AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !autoinc_ff && !tx_enqueued |=> $stable(tx_pointer_ff))
    else $error("pointer moved without auto increment");
  AST_RELOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tx_enqueued |=> tx_pointer_ff == $past(tx_next_free))
    else $error("pointer not reloaded after enqueue");
  AST_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_cmd && reg_be[0] && reg_wdata[`QDC_RELEASE] |=> release_req_ff)
    else $error("release request not raised");
  AST_REL_CLR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    release_req_ff && release_done && !wr_cmd |=> !release_req_ff)
    else $error("release bit did not self clear");
  AST_DEQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rx_frame_read_done |=> rxq_dequeue_ff == $past(adeq_ff))
    else $error("auto dequeue mismatch");
  AST_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frm_en_ff && frm_live |=> rx_irq_req_ff)
    else $error("frame limit did not raise request");
  AST_IRQ_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !dur_en_ff && !byte_en_ff && !frm_en_ff |=> !rx_irq_req_ff)
    else $error("request raised with all causes off");
  AST_ALIGN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_cmd && reg_be[1] |=> ip_align_offset_en_ff == $past(reg_wdata[`QDC_IP_ALIGN]))
    else $error("align offset not written");
endmodule : qdc_queue_ctrl
`default_nettype wire

// *** common/qdc_defs.svh ***
// What this block does
// - duration cause flag, bit 12, read-only, refreshed by ack of interrupt bit 13
// - byte count cause flag, bit 11, read-only, refreshed by ack of bit 13
// - frame count cause flag, bit 10, read-only, refreshed by ack of bit 13
// - bit 9 set inserts two bytes before frame header; resets to zero
// - bit 7 enables interrupt when queue time exceeds duration limit
// - bit 6 enables interrupt when queued bytes exceed byte limit
// - bit 5 enables interrupt when queued frames exceed frame limit
// - bit 4 set dequeues a frame automatically once fully read
// - write-only bit 3 opens FIFO access and blocks all other registers
// - writing one to bit 0 releases the error frame; self-clears when done
// - pointer bit 14 set steps the TX pointer by 1, 2 or 4 per data write; data reads leave it
// - with bit 14 clear the TX pointer stays put on data accesses
// - 11-bit read-only TX pointer, reset zero, reloaded after each enqueue
// - duration limit counts microseconds, largest value 0xCFFF
`ifndef QDC_DEFS_SVH
`define QDC_DEFS_SVH

// ==========================================
// register map, halfword index of the offset
`define QDC_OFF_CMD 8'h82
`define QDC_OFF_PTR 8'h84
`define QDC_IDX_CMD 7'h41
`define QDC_IDX_PTR 7'h42

// ==========================================
// field positions
`define QDC_DUR_ST 12
`define QDC_BYTE_ST 11
`define QDC_FRM_ST 10
`define QDC_IP_ALIGN 9
`define QDC_DUR_EN 7
`define QDC_BYTE_EN 6
`define QDC_FRM_EN 5
`define QDC_ADEQ 4
`define QDC_DMA 3
`define QDC_RELEASE 0
`define QDC_AUTOINC 14
`define QDC_PTR_HI 10

// ==========================================
// reset values and steps
`define QDC_BIT_RST 1'b0
`define QDC_PTR_RST 11'h000
`define QDC_WORD_RST 16'h0000
`define QDC_STEP_B 11'h001
`define QDC_STEP_W 11'h002
`define QDC_STEP_D 11'h004

// ==========================================
// timing
`define QDC_CLK_NS 40
`define QDC_US_NS 1000
`define QDC_US_CYC ((`QDC_US_NS + `QDC_CLK_NS - 1) / `QDC_CLK_NS)
`define QDC_DUR_MAX 16'hCFFF
`define QDC_US_SAT 16'hFFFF

`endif

// *** common/qdc_pkg.sv ***
`default_nettype none
package qdc_pkg;
  // size of one data register access
  typedef enum logic [1:0] {
    QDC_SZ_BYTE,
    QDC_SZ_WORD,
    QDC_SZ_DWORD
  } qdc_size_e;
endpackage : qdc_pkg
`default_nettype wire

// *** logic/qdc_us_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "qdc_defs.svh"
module qdc_us_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // queue state and limit
  input wire logic run,
  input wire logic [15:0] limit,
  // result
  output logic over_ff
);
  logic [4:0] pre_ff;
  logic [4:0] nxt_pre;
  logic [15:0] us_ff;
  logic [15:0] nxt_us;
  logic nxt_over;
  logic [15:0] cap;

  // ==========================================
  // microsecond count since first frame queued
  always_comb begin
    cap = (limit > `QDC_DUR_MAX) ? `QDC_DUR_MAX : limit;
    nxt_pre = pre_ff;
    nxt_us = us_ff;
    if (!run) begin
      nxt_pre = 5'h00;
      nxt_us = `QDC_WORD_RST;
    end else if (pre_ff == 5'(`QDC_US_CYC - 1)) begin
      nxt_pre = 5'h00;
      // saturate so a stale queue never wraps back under the limit
      if (us_ff != `QDC_US_SAT) begin
        nxt_us = 16'(us_ff + 16'h0001);
      end
    end else begin
      nxt_pre = 5'(pre_ff + 5'h01);
    end
    nxt_over = run && (us_ff > cap);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 5'h00;
      us_ff <= `QDC_WORD_RST;
      over_ff <= `QDC_BIT_RST;
    end else begin
      pre_ff <= nxt_pre;
      us_ff <= nxt_us;
      over_ff <= nxt_over;
    end
  end

  AST_DUR_OVER: assert property (@(posedge ref_clk) disable iff (!rst_n)
    run && (us_ff > cap) |=> over_ff)
    else $error("duration limit passed without cause");
  AST_DUR_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !run |=> !over_ff && us_ff == 16'h0000)
    else $error("duration timer runs on empty queue");
endmodule : qdc_us_timer
`default_nettype wire

// *** logic/qdc_cause_flag.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "qdc_defs.svh"
module qdc_cause_flag (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // cause inputs
  input wire logic en,
  input wire logic live,
  input wire logic ack,
  // flag
  output logic flag_ff
);
  logic nxt_flag;

  // ==========================================
  // sticky cause, refreshed on interrupt ack
  always_comb begin
    // a cause still present at ack sets again: set wins over clear
    nxt_flag = (en && live) || (flag_ff && !ack);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= `QDC_BIT_RST;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  AST_FLAG_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    en && live |=> flag_ff)
    else $error("cause flag missed its cause");
  AST_FLAG_ACK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ack && !(en && live) |=> !flag_ff)
    else $error("cause flag not refreshed by ack");
endmodule : qdc_cause_flag
`default_nettype wire

// *** testbench/qdc_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module qdc_host_model (
  // clock
  input wire logic ref_clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [1:0] reg_be,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_ff,
  input wire logic reg_ack_ff,
  // data register port
  output logic fifo_req,
  output logic fifo_wr,
  output var qdc_pkg::qdc_size_e fifo_size
);
  // ==========================================
  // idle levels
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_be = 2'h3;
    reg_wdata = 16'h0000;
    fifo_req = 1'b0;
    fifo_wr = 1'b0;
    fifo_size = qdc_pkg::QDC_SZ_BYTE;
  end

  // ==========================================
  // register access, answer awaited a few cycles at most
  task automatic reg_access(input logic wr, input logic [7:0] a, input logic [1:0] be,
                            input logic [15:0] d, output logic [15:0] r, output logic ok);
    ok = 1'b0;
    r = 16'h0000;
    @(posedge ref_clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_be <= be;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // released lines show garbage, not the last value
    reg_addr <= ~a;
    reg_wdata <= ~d;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge ref_clk);
      if (reg_ack_ff === 1'b1) begin
        ok = 1'b1;
        r = reg_rdata_ff;
      end
    end
  endtask : reg_access

  // ==========================================
  // data register access
  task automatic fifo_access(input logic wr, input qdc_pkg::qdc_size_e sz);
    @(posedge ref_clk);
    fifo_req <= 1'b1;
    fifo_wr <= wr;
    fifo_size <= sz;
    @(posedge ref_clk);
    fifo_req <= 1'b0;
    fifo_wr <= ~wr;
  endtask : fifo_access

  // ==========================================
  // frame buffer transfer done, give registers back
  task automatic close_dma(input logic [15:0] cmd, output logic ok);
    logic [15:0] r;
    reg_access(1'b1, 8'h82, 2'h3, cmd & 16'hFFF7, r, ok);
  endtask : close_dma

  // ==========================================
  // error frame release, then poll until cleared
  task automatic release_and_poll(input logic [15:0] cmd, output int polls, output logic ok);
    logic [15:0] r;
    polls = 0;
    reg_access(1'b1, 8'h82, 2'h3, cmd | 16'h0001, r, ok);
    r = 16'h0001;
    while (ok && r[0] && polls < 20) begin
      polls++;
      reg_access(1'b0, 8'h82, 2'h3, 16'h0000, r, ok);
    end
    if (r[0] !== 1'b0) begin
      ok = 1'b0;
    end
  endtask : release_and_poll
endmodule : qdc_host_model
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
  // ==========================================
  // signals
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr, reg_rd, reg_ack_ff, reg_refused_ff, fifo_req, fifo_wr;
  logic fifo_grant_ff, fifo_refused_ff, dma_access_ff, quiet, ok, fe;
  logic rx_irq_ack, rx_frame_read_done, release_done, tx_enqueued;
  logic rx_irq_req_ff, ip_align_offset_en_ff, rxq_dequeue_ff, release_req_ff;
  logic [7:0] reg_addr;
  logic [1:0] reg_be;
  logic [15:0] reg_wdata, reg_rdata_ff, rxq_frames, rxq_bytes;
  logic [15:0] frame_limit, byte_limit, duration_limit;
  logic [10:0] tx_next_free, tx_pointer_ff, v;
  qdc_pkg::qdc_size_e fifo_size, sz;
  logic [31:0] seed = 32'h0000002D;
  logic [17:0] rq[$];
  logic [17:0] re;
  logic fq[$];
  int fails = 0;
  int n_compared = 0;
  int polls;

  always #20 ref_clk = ~ref_clk;

  qdc_queue_ctrl qdc_queue_ctrl_inst (.ref_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_be,
    .reg_wdata, .reg_rdata_ff, .reg_ack_ff, .reg_refused_ff, .fifo_req, .fifo_wr, .fifo_size,
    .fifo_grant_ff, .fifo_refused_ff, .dma_access_ff, .rxq_frames, .rxq_bytes, .frame_limit,
    .byte_limit, .duration_limit, .rx_irq_ack, .rx_frame_read_done, .release_done,
    .rx_irq_req_ff, .ip_align_offset_en_ff, .rxq_dequeue_ff, .release_req_ff, .tx_enqueued,
    .tx_next_free, .tx_pointer_ff);

  qdc_host_model qdc_host_model_inst (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_be,
    .reg_wdata, .reg_rdata_ff, .reg_ack_ff, .fifo_req, .fifo_wr, .fifo_size);

  // ==========================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic stop_test();
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic acc(input logic wr, input logic [7:0] a, input logic [1:0] be,
                     input logic [15:0] d, input logic [15:0] e, input logic rf);
    logic [15:0] r;
    logic k;
    rq.push_back({!wr, rf, e});
    qdc_host_model_inst.reg_access(wr, a, be, d, r, k);
    if (!k) begin
      fails++;
      stop_test();
    end
  endtask : acc

  // ==========================================
  // answer watcher, oldest note first
  always @(negedge ref_clk) begin
    if (reg_ack_ff === 1'b1 && !quiet) begin
      re = (rq.size() > 0) ? rq.pop_front() : 18'h3FFFF;
      `CHK("refused", re[16], reg_refused_ff)
      if (re[17]) `CHK("rdata", re[15:0], reg_rdata_ff)
    end
    if (fifo_grant_ff === 1'b1 || fifo_refused_ff === 1'b1) begin
      fe = (fq.size() > 0) ? fq.pop_front() : 1'bx;
      `CHK("grant", fe, fifo_grant_ff)
      `CHK("fifo refused", !fe, fifo_refused_ff)
    end
  end

  // ==========================================
  // main sequence
  initial begin
    quiet = 1'b0;
    {rx_irq_ack, rx_frame_read_done, release_done, tx_enqueued} = 4'h0;
    rxq_frames = 16'h0000;
    rxq_bytes = 16'h0000;
    frame_limit = 16'h0001;
    byte_limit = 16'h0032;
    duration_limit = 16'h0002;
    tx_next_free = 11'h000;
    v = 11'h000;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    acc(1'b0, 8'h82, 2'h3, 16'h0000, 16'h0000, 1'b0);
    acc(1'b0, 8'h84, 2'h3, 16'h0000, 16'h0000, 1'b0);
    acc(1'b0, 8'h90, 2'h3, 16'h0000, 16'h0000, 1'b0);
    // reserved and read-only bits must not stick
    acc(1'b1, 8'h82, 2'h3, 16'hFFF6, 16'h0000, 1'b0);
    acc(1'b1, 8'h82, 2'h1, 16'h0000, 16'h0000, 1'b0);
    acc(1'b0, 8'h82, 2'h3, 16'h0000, 16'h0200, 1'b0);
    acc(1'b1, 8'h82, 2'h3, 16'h02F0, 16'h0000, 1'b0);
    `CHK("align", 1'b1, ip_align_offset_en_ff)
    @(posedge ref_clk);
    rxq_frames <= 16'h0003;
    rxq_bytes <= 16'h0064;
    repeat (120) @(posedge ref_clk);
    acc(1'b0, 8'h82, 2'h3, 16'h0000, 16'h1EF0, 1'b0);
    `CHK("irq", 1'b1, rx_irq_req_ff)
    @(posedge ref_clk);
    rxq_frames <= 16'h0000;
    rxq_bytes <= 16'h0000;
    repeat (6) @(posedge ref_clk);
    acc(1'b0, 8'h82, 2'h3, 16'h0000, 16'h1EF0, 1'b0);
    `CHK("irq", 1'b0, rx_irq_req_ff)
    @(posedge ref_clk);
    rx_irq_ack <= 1'b1;
    @(posedge ref_clk);
    rx_irq_ack <= 1'b0;
    acc(1'b0, 8'h82, 2'h3, 16'h0000, 16'h02F0, 1'b0);
    // only the frame cause enabled
    acc(1'b1, 8'h82, 2'h3, 16'h0220, 16'h0000, 1'b0);
    @(posedge ref_clk);
    rxq_frames <= 16'h0003;
    rxq_bytes <= 16'h0064;
    repeat (120) @(posedge ref_clk);
    rxq_frames <= 16'h0000;
    rxq_bytes <= 16'h0000;
    acc(1'b0, 8'h82, 2'h3, 16'h0000, 16'h0620, 1'b0);
    @(posedge ref_clk);
    rx_irq_ack <= 1'b1;
    @(posedge ref_clk);
    rx_irq_ack <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      acc(1'b1, 8'h82, 2'h3, (k == 0) ? 16'h02F0 : 16'h02E0, 16'h0000, 1'b0);
      @(posedge ref_clk);
      rx_frame_read_done <= 1'b1;
      @(posedge ref_clk);
      rx_frame_read_done <= 1'b0;
      @(negedge ref_clk);
      `CHK("dequeue", 1'(k == 0), rxq_dequeue_ff)
    end
    @(posedge ref_clk);
    quiet = 1'b1;
    fork
      qdc_host_model_inst.release_and_poll(16'h02F0, polls, ok);
      begin
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK("release", 1'b1, release_req_ff)
        @(posedge ref_clk);
        release_done <= 1'b1;
        @(posedge ref_clk);
        release_done <= 1'b0;
      end
    join
    @(posedge ref_clk);
    quiet = 1'b0;
    `CHK("polled", 2'b11, {ok, 1'(polls > 1)})
    `CHK("release", 1'b0, release_req_ff)
    acc(1'b1, 8'h84, 2'h3, 16'h47FF, 16'h0000, 1'b0);
    acc(1'b0, 8'h84, 2'h3, 16'h0000, 16'h4000, 1'b0);
    v = 11'(xs());
    @(posedge ref_clk);
    tx_next_free <= v;
    tx_enqueued <= 1'b1;
    @(posedge ref_clk);
    tx_enqueued <= 1'b0;
    acc(1'b0, 8'h84, 2'h3, 16'h0000, {5'b01000, v}, 1'b0);
    fq.push_back(1'b0);
    qdc_host_model_inst.fifo_access(1'b1, qdc_pkg::QDC_SZ_BYTE);
    // autoinc on, then off; pointer writes refused while the buffer is open
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        acc(1'b1, 8'h84, 2'h3, 16'h0000, 16'h0000, 1'b0);
      end
      // write to the unmapped offset 0x86 while registers are still reachable
      acc(1'b1, 8'h86, 2'h3, 16'h0000, 16'h0000, 1'b0);
      acc(1'b1, 8'h82, 2'h3, 16'h02F8, 16'h0000, 1'b0);
      `CHK("dma", 1'b1, dma_access_ff)
      acc(1'b0, 8'h82, 2'h3, 16'h0000, 16'h02F0, 1'b0);
      acc(1'b0, 8'h84, 2'h3, 16'h0000, 16'h0000, 1'b1);
      acc(1'b1, 8'h84, 2'h3, 16'h0000, 16'h0000, 1'b1);
      for (int j = 0; j < 5; j++) begin
        sz = qdc_pkg::qdc_size_e'(2'(xs() % 3));
        fq.push_back(1'b1);
        qdc_host_model_inst.fifo_access(1'(j != 4), sz);
        if (k == 0 && j != 4) begin
          v = v + (11'h001 << sz);
        end
      end
      rq.push_back(18'h00000);
      qdc_host_model_inst.close_dma(16'h02F8, ok);
      acc(1'b0, 8'h84, 2'h3, 16'h0000, {1'b0, 1'(k == 0), 3'b000, v}, 1'b0);
      `CHK("dma", 2'b10, {ok, dma_access_ff})
    end
    stop_test();
  end
endmodule : tb
`default_nettype wire
